//--- sctl_map.svh
`ifndef SCTL_MAP_SVH
`define SCTL_MAP_SVH
`define SCTL_BIT_CTXNUM 20
`define SCTL_BIT_WRNX 19
`define SCTL_BIT_WAITEV 18
`define SCTL_BIT_RSVD 17
`define SCTL_BIT_WAITIRQ 16
`define SCTL_BIT_CTYPE 15
`define SCTL_BIT_ZBLK 14
`define SCTL_BIT_KEYB 13
`define SCTL_BIT_ICACHE 12
`define SCTL_BIT_EXSYNC 11
`define SCTL_BIT_PREDRES 10
`define SCTL_BIT_UMASK 9
`define SCTL_BIT_ENDSW 8
`define SCTL_BIT_CONDBLK 7
`define SCTL_BIT_UNALIGN 6
`define SCTL_BIT_MMU 0
`define SCTL_RST_FIELDS 15'h0000
`define SCTL_EC_WAIT 6'h01
`define SCTL_EC_SYSREG 6'h18
`define SCTL_EC_UNDEF 6'h00
`endif

//--- sctl_pkg.sv
package sctl_pkg;
  typedef struct packed {
    logic hostMode;
    logic trapGeneral;
    logic defaultCacheable;
    logic el2Enabled;
  } sctl_hyp_t;
  typedef struct packed {
    logic valid;
    logic toEl2;
    logic [5:0] excClass;
  } sctl_trap_t;
  typedef struct packed {
    logic ctxNum;
    logic waitEvent;
    logic waitIrq;
    logic cacheType;
    logic zeroBlock;
    logic maskMove;
    logic predRestrict;
    logic endianSwitch;
    logic condBlock;
    logic timed;
    logic state32;
    logic condPass;
    logic waitBlocks;
  } sctl_instr_t;
endpackage : sctl_pkg

//--- sctl_el1_control.sv
// Notes on behaviour
// - Bit 20 traps EL0 context-number access in 64-bit state; reads one if absent.
// - Bit 19 forces writable regions execute-never while translation enabled.
// - Never-execute bit may be cached; change seen after invalidation.
// - Bit 18 clear traps EL0 wait-for-event, class 0x01, to EL1 or EL2.
// - Timed wait-for-event is trapped the same way when supported.
// - 32-bit conditional waits trap only when condition passes.
// - Wait trap required whenever the wait would block without wakeup.
// - Bit 16 clear traps EL0 wait-for-interrupt, class 0x01.
// - Timed wait-for-interrupt is trapped the same way when supported.
// - Bit 15 clear traps EL0 cache type reads, 64-bit state, class 0x18.
// - Bit 14 clear traps EL0 zero-block instructions, class 0x18.
// - Bit 13 enables key-B data pointer signing and authentication.
// - Bit 12 instruction cacheability; forced cacheable by default-cacheable; resets zero.
// - Bit 11 selects exit synchronisation; reads one if feature absent.
// - Bit 10 enables EL0 prediction-restriction instructions.
// - Bit 9 clear traps EL0 mask-bit moves, 64-bit state, class 0x18.
// - Bit 8 blocks EL0 endian switch; reads one without mixed endian.
// - Bit 7 disables conditional blocks; reads zero and ignores writes if absent.
// - Bit 6 allows unaligned access under relaxed alignment feature.
// - Host mode with general trap makes these fields ineffective; keybAuthEn, exitSync and unalignedAllow still follow bits 13, 11 and 6 here.
// - All fields except instruction cacheability reset unknown; here zero.
// - Bit 0 is translation enable; never-execute forcing depends on it.
// - EL0 reads or writes of this register are undefined.
`include "sctl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sctl_el1_control
  import sctl_pkg::*;
#(
  parameter bit HAS_CTXNUM = 1'h1,
  parameter bit HAS_HOSTVIRT = 1'h1,
  parameter bit HAS_TIMEDWAIT = 1'h1,
  parameter bit HAS_PTRAUTH = 1'h1,
  parameter bit HAS_EXITSYNC = 1'h1,
  parameter bit HAS_PREDRES = 1'h1,
  parameter bit HAS_MIXEND = 1'h1,
  parameter bit EL0_HAS32 = 1'h1,
  parameter bit HAS_CONDBLK = 1'h1,
  parameter bit HAS_RELAXALIGN = 1'h1
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [1:0] curEl,
  input wire logic [63:0] regWdata,
  input wire sctl_hyp_t hypCfg,
  input wire sctl_instr_t instr,
  output logic [63:0] regRdata,
  output logic regUndef,
  output var sctl_trap_t trapOut,
  output logic forceXn,
  output logic icacheable,
  output logic keybAuthEn,
  output logic exitSync,
  output logic unalignedAllow
);
  // Register group
  logic [20:6] fields_ff;
  logic [20:6] nxt_fields;
  logic mmuEn_ff;
  logic nxt_mmuEn;
  logic [63:0] regRdata_ff;
  logic [63:0] nxt_regRdata;
  logic regUndef_ff;
  logic nxt_regUndef;
  // Trap group
  sctl_trap_t trap_ff;
  sctl_trap_t nxt_trap;
  // Level group
  logic forceXn_ff;
  logic nxt_forceXn;
  logic icache_ff;
  logic nxt_icache;
  logic keyb_ff;
  logic nxt_keyb;
  logic exitSync_ff;
  logic nxt_exitSync;
  logic unalign_ff;
  logic nxt_unalign;
  // Decode
  logic [20:6] eff;
  logic hostOverride;
  logic el0Access;
  logic trapHit;
  logic waitEvHit;
  logic waitIrqHit;
  logic sysregHit;
  logic undefHit;

  // Fixed bits of absent features
  function automatic logic [20:6] fixFields(input logic [20:6] v);
    logic [20:6] r;
    r = v;
    r[`SCTL_BIT_RSVD] = 1'h0;
    if (!HAS_CTXNUM)
    begin
      r[`SCTL_BIT_CTXNUM] = 1'h1;
    end
    if (!HAS_PTRAUTH)
    begin
      r[`SCTL_BIT_KEYB] = 1'h0;
    end
    if (!HAS_EXITSYNC)
    begin
      r[`SCTL_BIT_EXSYNC] = 1'h1;
    end
    if (!HAS_PREDRES)
    begin
      r[`SCTL_BIT_PREDRES] = 1'h0;
    end
    if (!HAS_MIXEND || !EL0_HAS32)
    begin
      r[`SCTL_BIT_ENDSW] = 1'h1;
    end
    if (!EL0_HAS32)
    begin
      r[`SCTL_BIT_CONDBLK] = 1'h1;
    end
    else if (!HAS_CONDBLK)
    begin
      r[`SCTL_BIT_CONDBLK] = 1'h0;
    end
    if (!HAS_RELAXALIGN)
    begin
      r[`SCTL_BIT_UNALIGN] = 1'h0;
    end
    return r;
  endfunction : fixFields

  // Wait trap decode shared by both wait kinds
  function automatic logic waitTrap(
    input logic isWait,
    input logic timed,
    input logic trapOff,
    input logic state32,
    input logic condPass,
    input logic blocks
  );
    logic kindOk;
    kindOk = isWait && (!timed || HAS_TIMEDWAIT);
    return kindOk && !trapOff && (!state32 || condPass) && blocks;
  endfunction : waitTrap

  assign eff = fixFields(fields_ff);
  assign hostOverride = HAS_HOSTVIRT && hypCfg.hostMode && hypCfg.trapGeneral;
  assign el0Access = (regWrite || regRead) && curEl == 2'h0;

  assign waitEvHit = waitTrap(instr.waitEvent, instr.timed, eff[`SCTL_BIT_WAITEV],
    instr.state32, instr.condPass, instr.waitBlocks);
  assign waitIrqHit = waitTrap(instr.waitIrq, instr.timed, eff[`SCTL_BIT_WAITIRQ],
    instr.state32, instr.condPass, instr.waitBlocks);
  assign sysregHit = !instr.state32
    && ((instr.cacheType && !eff[`SCTL_BIT_CTYPE])
    || (instr.zeroBlock && !eff[`SCTL_BIT_ZBLK])
    || (instr.maskMove && !eff[`SCTL_BIT_UMASK])
    || (instr.ctxNum && eff[`SCTL_BIT_CTXNUM]));
  assign undefHit = (instr.predRestrict && !eff[`SCTL_BIT_PREDRES])
    || (instr.state32 && instr.endianSwitch && eff[`SCTL_BIT_ENDSW])
    || (instr.state32 && instr.condBlock && eff[`SCTL_BIT_CONDBLK]);

  // Register access
  always_comb
  begin
    nxt_fields = fields_ff;
    nxt_mmuEn = mmuEn_ff;
    nxt_regRdata = regRdata_ff;
    nxt_regUndef = 1'h0;
    if (el0Access)
    begin
      nxt_regUndef = 1'h1;
    end
    else
    begin
      if (regWrite)
      begin
        nxt_fields = fixFields(regWdata[20:6]);
        nxt_mmuEn = regWdata[`SCTL_BIT_MMU];
      end
      if (regRead)
      begin
        nxt_regRdata = 64'h0;
        nxt_regRdata[20:6] = eff;
        nxt_regRdata[`SCTL_BIT_MMU] = mmuEn_ff;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      fields_ff <= `SCTL_RST_FIELDS;
      mmuEn_ff <= 1'h0;
      regRdata_ff <= 64'h0;
      regUndef_ff <= 1'h0;
    end
    else
    begin
      fields_ff <= nxt_fields;
      mmuEn_ff <= nxt_mmuEn;
      regRdata_ff <= nxt_regRdata;
      regUndef_ff <= nxt_regUndef;
    end
  end

  // Trap decode, fixed priority
  always_comb
  begin
    trapHit = 1'h0;
    nxt_trap = '0;
    if (curEl == 2'h0 && !hostOverride)
    begin
      if (waitEvHit)
      begin
        trapHit = 1'h1;
        nxt_trap.excClass = `SCTL_EC_WAIT;
      end
      else if (waitIrqHit)
      begin
        trapHit = 1'h1;
        nxt_trap.excClass = `SCTL_EC_WAIT;
      end
      else if (sysregHit)
      begin
        trapHit = 1'h1;
        nxt_trap.excClass = `SCTL_EC_SYSREG;
      end
      else if (undefHit)
      begin
        trapHit = 1'h1;
        nxt_trap.excClass = `SCTL_EC_UNDEF;
      end
    end
    nxt_trap.valid = trapHit;
    nxt_trap.toEl2 = trapHit && hypCfg.el2Enabled && hypCfg.trapGeneral;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      trap_ff <= '0;
    end
    else
    begin
      trap_ff <= nxt_trap;
    end
  end

  // Field-derived levels
  always_comb
  begin
    // Stage-1 consumers may latch this; no invalidation tracked here
    nxt_forceXn = !hostOverride && mmuEn_ff && eff[`SCTL_BIT_WRNX];
    nxt_icache = !hostOverride
      && (hypCfg.defaultCacheable || eff[`SCTL_BIT_ICACHE]);
    nxt_keyb = eff[`SCTL_BIT_KEYB];
    nxt_exitSync = eff[`SCTL_BIT_EXSYNC];
    nxt_unalign = eff[`SCTL_BIT_UNALIGN];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      forceXn_ff <= 1'h0;
      icache_ff <= 1'h0;
      keyb_ff <= 1'h0;
      exitSync_ff <= 1'h0;
      unalign_ff <= 1'h0;
    end
    else
    begin
      forceXn_ff <= nxt_forceXn;
      icache_ff <= nxt_icache;
      keyb_ff <= nxt_keyb;
      exitSync_ff <= nxt_exitSync;
      unalign_ff <= nxt_unalign;
    end
  end

  // Outputs straight from flops
  assign regRdata = regRdata_ff;
  assign regUndef = regUndef_ff;
  assign trapOut = trap_ff;
  assign forceXn = forceXn_ff;
  assign icacheable = icache_ff;
  assign keybAuthEn = keyb_ff;
  assign exitSync = exitSync_ff;
  assign unalignedAllow = unalign_ff;
endmodule : sctl_el1_control
`default_nettype wire

//--- sctl_el1_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sctl_el1_control_assertions
  import sctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [1:0] curEl,
  input wire logic [63:0] regWdata,
  input wire sctl_hyp_t hypCfg,
  input wire sctl_instr_t instr,
  input wire logic [63:0] regRdata,
  input wire logic regUndef,
  input wire sctl_trap_t trapOut,
  input wire logic forceXn,
  input wire logic keybAuthEn
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Accepted write followed by a quiet cycle
  sequence elWr;
    regWrite && curEl != 2'h0 && !hypCfg.hostMode ##1 !regWrite && !hypCfg.hostMode;
  endsequence
  undef_on_el0_a: assert property ((regRead || regWrite) && curEl == 2'h0 |=> regUndef)
    else $error("el0 access not refused");
  undef_cause_a: assert property (regUndef |-> $past(curEl) == 2'h0 && ($past(regRead) || $past(regWrite)))
    else $error("spurious undefined pulse");
  rsvd_zero_a: assert property (regRdata[17] == 1'h0)
    else $error("reserved bit reads one");
  trap_route_a: assert property (trapOut.valid |-> trapOut.toEl2 == ($past(hypCfg.el2Enabled) && $past(hypCfg.trapGeneral)))
    else $error("trap routed wrongly");
  trap_el0_a: assert property (trapOut.valid |-> $past(curEl) == 2'h0 && !($past(hypCfg.hostMode) && $past(hypCfg.trapGeneral)))
    else $error("trap outside el0 or in host mode");
  wait_class_a: assert property (trapOut.valid && trapOut.excClass == 6'h01 |-> $past(instr.waitEvent) || $past(instr.waitIrq))
    else $error("wait class without wait");
  xn_force_a: assert property ((regWdata[19] && regWdata[0]) ##0 elWr |=> forceXn)
    else $error("execute-never not forced");
  keyb_en_a: assert property (elWr |=> keybAuthEn == $past(regWdata[13], 2))
    else $error("key-B enable wrong");
endmodule : sctl_el1_control_assertions
`default_nettype wire

//--- sctl_el1_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sctl_el1_control_tb;
  import sctl_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, regWrite = 1'h0, regRead = 1'h0;
  logic [1:0] curEl = 2'h1;
  logic [63:0] regWdata = 64'h0, regRdata, d;
  logic [6:0] e;
  sctl_hyp_t hypCfg = '0;
  sctl_instr_t instr = '0;
  sctl_trap_t trapOut;
  logic regUndef, forceXn, icacheable, keybAuthEn, exitSync, unalignedAllow;
  int n_errors = 0, checks = 0, seed = 32'h8AD7A5FD;
  always #2.5 clk_sys = ~clk_sys;
  sctl_el1_control u_dut (.clk_sys, .reset_n, .regWrite, .regRead, .curEl, .regWdata, .hypCfg,
    .instr, .regRdata, .regUndef, .trapOut, .forceXn, .icacheable, .keybAuthEn, .exitSync,
    .unalignedAllow);
  function automatic logic [6:0] tx(int j, logic [63:0] v, sctl_hyp_t h);
    int b[9] = '{20, 18, 16, 15, 14, 9, 10, 8, 7};
    logic hit = (v[b[j]] == (j == 0 || j > 6)) && !(h.hostMode && h.trapGeneral);
    return {hit, hit ? ((j == 1 || j == 2) ? 6'h01 : (j < 6 ? 6'h18 : 6'h00)) : 6'h00};
  endfunction : tx
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic acc(input logic w, input logic [1:0] el, input logic [63:0] v);
    @(negedge clk_sys);
    regWrite = w;
    regRead = !w;
    curEl = el;
    regWdata = v;
    @(negedge clk_sys);
    regWrite = 1'h0;
    regRead = 1'h0;
    chk(regUndef, el == 2'h0);
  endtask : acc
  task automatic fire(input int j);
    @(negedge clk_sys);
    hypCfg = sctl_hyp_t'(4'($random(seed)));
    curEl = 2'h0;
    instr = '0;
    instr[12 - j] = 1'h1;
    instr.waitBlocks = 1'h1;
    instr.state32 = (j > 6);
    instr.timed = 1'($random(seed));
    e = tx(j, d, hypCfg);
    @(negedge clk_sys);
    instr = '0;
    hypCfg = '0;
    chk({trapOut.valid, trapOut.valid ? trapOut.excClass : 6'h00}, e);
  endtask : fire
  initial
  begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'h1;
    acc(1'h0, 2'h1, 64'h0);
    chk(regRdata, 64'h0);
    for (int k = 0; k < 40; k++)
    begin
      d = {$random(seed), $random(seed)};
      acc(1'h1, 2'($random(seed)) | 2'h1, d);
      acc(1'h1, 2'h0, ~d);
      acc(1'h0, 2'h1, 64'h0);
      chk(regRdata, d & 64'h1DFFC1);
      chk({forceXn, icacheable, keybAuthEn, exitSync, unalignedAllow},
        {d[19] & d[0], d[12], d[13], d[11], d[6]});
      for (int j = 0; j < 9; j++)
        fire(j);
    end
    end_sim();
  end
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : sctl_el1_control_tb
bind sctl_el1_control sctl_el1_control_assertions u_chk (.clk_sys, .reset_n, .regWrite, .regRead,
  .curEl, .regWdata, .hypCfg, .instr, .regRdata, .regUndef, .trapOut, .forceXn, .keybAuthEn);
`default_nettype wire
